// ### etp_pkg.sv
// Purpose : Shared constants for the event trigger prescaler block.
// Assumes : 32-bit AXI4-Lite register slave, one word per register.
// Notes   : Offsets, field positions, reset values and bus codes only.
package etp_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ETP_OFS_PRESCALE = 8'h00; // event_prescale_ctrl
  localparam logic [7:0] ETP_OFS_SELECT   = 8'h04; // event_select_ctrl
  localparam logic [7:0] ETP_OFS_FLAG     = 8'h08; // event_flag_status
  localparam logic [7:0] ETP_OFS_CLEAR    = 8'h0C; // event_flag_clear
  localparam logic [7:0] ETP_OFS_FORCE    = 8'h10; // event_force_ctrl

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ETP_FLD_W          = 2;  // Width of period and count fields
  localparam int ETP_IRQ_PRD_LSB    = 0;  // irq_period
  localparam int ETP_IRQ_CNT_LSB    = 2;  // irq_event_count
  localparam int ETP_CONVA_PRD_LSB  = 8;  // conv_a_period
  localparam int ETP_CONVA_CNT_LSB  = 10; // conv_a_event_count
  localparam int ETP_SEL_IRQ_EN_BIT = 3;  // Interrupt enable
  localparam int ETP_SEL_CONVA_BIT  = 11; // conv_a_enable
  localparam int ETP_IRQ_BIT        = 0;  // Flag, clear and force: interrupt
  localparam int ETP_CONVA_BIT      = 2;  // Flag, clear and force: conv_a_flag

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] ETP_PRD_RST = 2'h0; // Period fields after reset
  localparam logic [1:0] ETP_CNT_RST = 2'h0; // Event counts after reset
  localparam logic       ETP_EN_RST  = 1'h0; // Enables after reset

  // ---------------------------------------------------------------
  // Bus response codes and handshake states
  // ---------------------------------------------------------------
  localparam logic [1:0] ETP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ETP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ETP_BUS_IDLE = 2'h0,  // Ready to take a request
    ETP_BUS_RESP = 2'h1   // Answer offered, waiting for ready
  } etp_bus_e;

endpackage

// ### etp_evt_step.sv
// Purpose : One prescale channel: counts event strobes and decides a pulse.
// Assumes : Period and gate are the values in force this cycle.
// Notes   : Purely combinational; the caller registers the count.
`timescale 1ns/1ps
module etp_evt_step #(
  parameter int CNT_W = 2
) (
  input  wire logic [CNT_W-1:0] cnt_i,    // Present event count
  input  wire logic [CNT_W-1:0] prd_i,    // Period in force (new if written)
  input  wire logic             evt_i,    // One-cycle event strobe
  input  wire logic             prd_wr_i, // Period written this cycle
  input  wire logic             gate_i,   // Pulse allowed this cycle
  input  wire logic             force_i,  // Software force request
  output logic                  fire_o,   // Pulse decided this cycle
  output logic [CNT_W-1:0]      cnt_o     // Next event count
);

  // ---------------------------------------------------------------
  // Count and pulse decision
  // ---------------------------------------------------------------
  logic             active; // Counter running
  logic             hold;   // Count parked at the period
  logic             inc;    // Add one this cycle
  logic [CNT_W-1:0] cand;   // Count after this cycle's event

  // A period write alongside an event still counts it
  assign active = (prd_i != '0) || prd_wr_i; // R11 R12 R01
  // Parked at the period while pulses are blocked
  assign hold   = !gate_i && (cnt_i == prd_i); // R05
  // At most one step per clock, saturating at the top
  assign inc    = evt_i && active && !hold && (cnt_i != '1); // R19
  assign cand   = cnt_i + CNT_W'(inc);
  // Pulse when the count meets the period, or when forced
  // An equal period write fires even if an event lands in the same cycle
  assign fire_o = gate_i && (prd_i != '0)
               && ((cand == prd_i)                   // R02 R14
                || (prd_wr_i && (cnt_i == prd_i))    // R09
                || force_i);                         // R13
  // Count restarts after each pulse
  assign cnt_o  = fire_o ? '0 : cand; // R04 R17

endmodule // etp_evt_step

// ### etp_event_trigger.sv
// Purpose : Event prescaler for interrupt and conversion A start pulses.
// Assumes : Event inputs are one-cycle strobes synchronous to sys_clk_i.
// Notes   : Registers reached over AXI4-Lite; one write and one read at a time.
`timescale 1ns/1ps

// Functional notes
// R01 - Conversion A period zero disables conversion A
// R02 - Conversion A pulse on first, second, third event
// R03 - Two-bit readable interrupt event count
// R04 - Interrupt pulse clears interrupt event count
// R05 - Blocked interrupt: count stops at period
// R06 - Interrupt period selects events per interrupt
// R07 - Interrupt only while enable is one
// R08 - Set flag withholds interrupt until cleared
// R09 - Period written equal to count fires
// R10 - Software never writes period below count
// R11 - Event during period write still counts
// R12 - Interrupt period zero disables counter; an event in the cycle that writes a zero period still counts
// R13 - Interrupt period zero ignores force bit
// R14 - Interrupt on first, second, third event
// R15 - Conversion A pulse only while enabled
// R16 - Conversion A pulses despite set flag
// R17 - Conversion A pulse clears its count
// R18 - Clear bit clears flag, reopens interrupts
// R19 - At most one count step per clock
// R20 - Reset zeroes counts and periods
module etp_event_trigger #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              irq_evt_i,            // Selected interrupt event
  input  wire logic              conv_a_evt_i,         // Selected conversion A event
  output logic                   pwm_irq_out_o,        // Interrupt pulse
  output logic                   adc_start_a_pulse_o   // Conversion A start pulse
);

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        irq_prd;     // irq_period
    logic [1:0]        irq_cnt;     // irq_event_count
    logic [1:0]        conva_prd;   // conv_a_period
    logic [1:0]        conva_cnt;   // conv_a_event_count
    logic              irq_en;      // Interrupt enable
    logic              conva_en;    // conv_a_enable
    logic              irq_flag;    // Latched interrupt flag
    logic              conva_flag;  // conv_a_flag
    logic              irq_pulse;   // Registered interrupt pulse
    logic              conva_pulse; // Registered conversion A pulse
    etp_pkg::etp_bus_e wr_st;       // Write channel state
    etp_pkg::etp_bus_e rd_st;       // Read channel state
    logic              aw_got;      // Write address held
    logic              w_got;       // Write data held
    logic [ADDR_W-1:0] wr_addr;     // Held write address
    logic [31:0]       wr_data;     // Held write data
    logic [3:0]        wr_strb;     // Held byte strobes
    logic [1:0]        bresp;       // Write answer code
    logic [31:0]       rdata;       // Read answer data
    logic [1:0]        rresp;       // Read answer code
  } etp_state_s;

  etp_state_s st_r;   // Registered state
  etp_state_s st_nxt; // Next state

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  logic            do_wr;      // Held write applied this cycle
  logic            wr_map;     // Held write address is a register
  logic            hit_ps;     // Write to event_prescale_ctrl
  logic            hit_sel;    // Write to event_select_ctrl
  logic            hit_clr;    // Write to event_flag_clear
  logic            hit_frc;    // Write to event_force_ctrl
  logic            clr_irq;    // Clear interrupt flag
  logic            clr_conva;  // Clear conversion A flag

  // Both halves of a write must be held before it takes effect
  assign do_wr   = (st_r.wr_st == etp_pkg::ETP_BUS_IDLE) && st_r.aw_got && st_r.w_got;
  assign hit_ps  = do_wr && (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_PRESCALE));
  assign hit_sel = do_wr && (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_SELECT));
  assign hit_clr = do_wr && (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_CLEAR));
  assign hit_frc = do_wr && (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_FORCE));
  assign wr_map  = (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_PRESCALE))
                || (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_SELECT))
                || (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_FLAG))
                || (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_CLEAR))
                || (st_r.wr_addr == ADDR_W'(etp_pkg::ETP_OFS_FORCE));

  // Clear bits act only when written one in byte lane 0
  assign clr_irq   = hit_clr && st_r.wr_strb[0] && st_r.wr_data[etp_pkg::ETP_IRQ_BIT]; // R18
  assign clr_conva = hit_clr && st_r.wr_strb[0] && st_r.wr_data[etp_pkg::ETP_CONVA_BIT];

  // ---------------------------------------------------------------
  // Channel inputs: index 0 interrupt, index 1 conversion A
  // ---------------------------------------------------------------
  logic [1:0][1:0] cnt_cur;   // Present counts
  logic [1:0][1:0] prd_new;   // Period in force this cycle
  logic [1:0][1:0] cnt_nxt;   // Next counts
  logic [1:0]      prd_wr;    // Period field written
  logic [1:0]      evt;       // Event strobes
  logic [1:0]      gate;      // Pulse allowed
  logic [1:0]      frc;       // Force requests
  logic [1:0]      fire;      // Pulse decided

  assign cnt_cur[0] = st_r.irq_cnt;
  assign cnt_cur[1] = st_r.conva_cnt;
  // Interrupt period lives in lane 0, conversion A period in lane 1
  assign prd_wr[0]  = hit_ps && st_r.wr_strb[0];
  assign prd_wr[1]  = hit_ps && st_r.wr_strb[1];
  // A written period takes effect in the same cycle as the write
  assign prd_new[0] = prd_wr[0] ? st_r.wr_data[etp_pkg::ETP_IRQ_PRD_LSB +: 2]
                                : st_r.irq_prd; // R06 R09
  assign prd_new[1] = prd_wr[1] ? st_r.wr_data[etp_pkg::ETP_CONVA_PRD_LSB +: 2]
                                : st_r.conva_prd;
  assign evt[0]     = irq_evt_i;
  assign evt[1]     = conv_a_evt_i;
  // Interrupt needs enable and a clear flag; conversion A needs enable only
  assign gate[0]    = st_r.irq_en && !st_r.irq_flag; // R07 R08
  assign gate[1]    = st_r.conva_en; // R15 R16
  assign frc[0]     = hit_frc && st_r.wr_strb[0] && st_r.wr_data[etp_pkg::ETP_IRQ_BIT];
  assign frc[1]     = hit_frc && st_r.wr_strb[0] && st_r.wr_data[etp_pkg::ETP_CONVA_BIT];

  // ---------------------------------------------------------------
  // Prescale channels
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    etp_evt_step #(
      .CNT_W    (etp_pkg::ETP_FLD_W)
    ) u_step (
      .cnt_i    (cnt_cur[ch]),
      .prd_i    (prd_new[ch]),
      .evt_i    (evt[ch]),
      .prd_wr_i (prd_wr[ch]),
      .gate_i   (gate[ch]),
      .force_i  (frc[ch]),
      .fire_o   (fire[ch]),
      .cnt_o    (cnt_nxt[ch])
    );
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [31:0] rd_word; // Value of the addressed register
  logic        rd_map;  // Read address is a register

  // Gathers register contents; unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_map  = 1'b1;
    case (ADDR_W'(s_axi_araddr_i))
      ADDR_W'(etp_pkg::ETP_OFS_PRESCALE): begin
        rd_word[etp_pkg::ETP_IRQ_PRD_LSB +: 2]   = st_r.irq_prd;
        rd_word[etp_pkg::ETP_IRQ_CNT_LSB +: 2]   = st_r.irq_cnt; // R03
        rd_word[etp_pkg::ETP_CONVA_PRD_LSB +: 2] = st_r.conva_prd;
        rd_word[etp_pkg::ETP_CONVA_CNT_LSB +: 2] = st_r.conva_cnt;
      end
      ADDR_W'(etp_pkg::ETP_OFS_SELECT): begin
        rd_word[etp_pkg::ETP_SEL_IRQ_EN_BIT] = st_r.irq_en;
        rd_word[etp_pkg::ETP_SEL_CONVA_BIT]  = st_r.conva_en;
      end
      ADDR_W'(etp_pkg::ETP_OFS_FLAG): begin
        rd_word[etp_pkg::ETP_IRQ_BIT]   = st_r.irq_flag;
        rd_word[etp_pkg::ETP_CONVA_BIT] = st_r.conva_flag;
      end
      // Clear and force are write-only and read zero
      ADDR_W'(etp_pkg::ETP_OFS_CLEAR): rd_word = 32'h0000_0000;
      ADDR_W'(etp_pkg::ETP_OFS_FORCE): rd_word = 32'h0000_0000;
      default: rd_map = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Periods and counts from the channels
    st_nxt.irq_prd   = prd_new[0];
    st_nxt.conva_prd = prd_new[1];
    st_nxt.irq_cnt   = cnt_nxt[0]; // R04
    st_nxt.conva_cnt = cnt_nxt[1]; // R17
    // Enables from the select register
    if (hit_sel && st_r.wr_strb[0]) begin
      st_nxt.irq_en = st_r.wr_data[etp_pkg::ETP_SEL_IRQ_EN_BIT];
    end
    if (hit_sel && st_r.wr_strb[1]) begin
      st_nxt.conva_en = st_r.wr_data[etp_pkg::ETP_SEL_CONVA_BIT];
    end
    // Flags: a new pulse wins over a clear in the same cycle
    st_nxt.irq_flag    = fire[0] | (st_r.irq_flag & ~clr_irq); // R18
    st_nxt.conva_flag  = fire[1] | (st_r.conva_flag & ~clr_conva);
    st_nxt.irq_pulse   = fire[0];
    st_nxt.conva_pulse = fire[1];

    // Write channel
    case (st_r.wr_st)
      etp_pkg::ETP_BUS_IDLE: begin
        // Address and data may arrive in either order
        if (s_axi_awvalid_i && !st_r.aw_got) begin
          st_nxt.aw_got  = 1'b1;
          st_nxt.wr_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !st_r.w_got) begin
          st_nxt.w_got   = 1'b1;
          st_nxt.wr_data = s_axi_wdata_i;
          st_nxt.wr_strb = s_axi_wstrb_i;
        end
        // Apply the held write and answer
        if (do_wr) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.wr_st  = etp_pkg::ETP_BUS_RESP;
          st_nxt.bresp  = wr_map ? etp_pkg::ETP_RESP_OKAY : etp_pkg::ETP_RESP_SLVERR;
        end
      end
      etp_pkg::ETP_BUS_RESP: begin
        // Hold the answer until the master takes it
        if (s_axi_bready_i) begin
          st_nxt.wr_st = etp_pkg::ETP_BUS_IDLE;
        end
      end
      default: st_nxt.wr_st = etp_pkg::ETP_BUS_IDLE;
    endcase

    // Read channel
    case (st_r.rd_st)
      etp_pkg::ETP_BUS_IDLE: begin
        // Capture the register value when the address is taken
        if (s_axi_arvalid_i) begin
          st_nxt.rd_st = etp_pkg::ETP_BUS_RESP;
          st_nxt.rdata = rd_word;
          st_nxt.rresp = rd_map ? etp_pkg::ETP_RESP_OKAY : etp_pkg::ETP_RESP_SLVERR;
        end
      end
      etp_pkg::ETP_BUS_RESP: begin
        if (s_axi_rready_i) begin
          st_nxt.rd_st = etp_pkg::ETP_BUS_IDLE;
        end
      end
      default: st_nxt.rd_st = etp_pkg::ETP_BUS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      // Nothing fires until software sets a period
      st_r           <= '0;
      st_r.irq_prd   <= etp_pkg::ETP_PRD_RST; // R20
      st_r.conva_prd <= etp_pkg::ETP_PRD_RST; // R20
      st_r.irq_cnt   <= etp_pkg::ETP_CNT_RST; // R20
      st_r.conva_cnt <= etp_pkg::ETP_CNT_RST; // R20
      st_r.irq_en    <= etp_pkg::ETP_EN_RST;
      st_r.conva_en  <= etp_pkg::ETP_EN_RST;
      st_r.wr_st     <= etp_pkg::ETP_BUS_IDLE;
      st_r.rd_st     <= etp_pkg::ETP_BUS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready_o     = (st_r.wr_st == etp_pkg::ETP_BUS_IDLE) && !st_r.aw_got;
  assign s_axi_wready_o      = (st_r.wr_st == etp_pkg::ETP_BUS_IDLE) && !st_r.w_got;
  assign s_axi_bvalid_o      = (st_r.wr_st == etp_pkg::ETP_BUS_RESP);
  assign s_axi_bresp_o       = st_r.bresp;
  assign s_axi_arready_o     = (st_r.rd_st == etp_pkg::ETP_BUS_IDLE);
  assign s_axi_rvalid_o      = (st_r.rd_st == etp_pkg::ETP_BUS_RESP);
  assign s_axi_rdata_o       = st_r.rdata;
  assign s_axi_rresp_o       = st_r.rresp;
  assign pwm_irq_out_o       = st_r.irq_pulse;
  assign adc_start_a_pulse_o = st_r.conva_pulse;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Zero period never yields a conversion A pulse
  conva_off_a: assert property ((st_r.conva_prd == 2'h0) && !prd_wr[1] |=> !adc_start_a_pulse_o) // R01
    else $error("conversion A pulse with zero period");

  // Event reaching the period gives a pulse next cycle, flag or not
  conva_reach_a: assert property (conv_a_evt_i && st_r.conva_en && !prd_wr[1]
      && (st_r.conva_prd != 2'h0) && (st_r.conva_cnt + 2'h1 == st_r.conva_prd)
      |=> adc_start_a_pulse_o && (st_r.conva_cnt == 2'h0)) // R02
    else $error("conversion A pulse missed");

  // Conversion A pulse only when it was enabled
  conva_enable_a: assert property ($rose(adc_start_a_pulse_o) |-> $past(st_r.conva_en)) // R15
    else $error("conversion A pulse while disabled");

  // Interrupt pulse clears the count and sets the flag
  irq_clear_cnt_a: assert property (fire[0] |=> pwm_irq_out_o && (st_r.irq_cnt == 2'h0)
      && st_r.irq_flag) // R04
    else $error("interrupt pulse without count clear");

  // Blocked interrupt parks the count at the period
  irq_hold_a: assert property ((!st_r.irq_en || st_r.irq_flag) && !do_wr
      && (st_r.irq_cnt == st_r.irq_prd) |=> $stable(st_r.irq_cnt)) // R05
    else $error("blocked count moved past period");

  // Pulses only when enabled with flag clear
  irq_gate_a: assert property (pwm_irq_out_o |-> $past(st_r.irq_en) && !$past(st_r.irq_flag)) // R07
    else $error("interrupt while disabled or pending");

  // Interrupt on the selected event
  irq_reach_a: assert property (irq_evt_i && st_r.irq_en && !st_r.irq_flag && !do_wr
      && (st_r.irq_prd != 2'h0) && (st_r.irq_cnt + 2'h1 == st_r.irq_prd)
      |=> pwm_irq_out_o) // R14
    else $error("interrupt missed at period");

  // Zero period: no interrupt, force ignored
  irq_zero_prd_a: assert property ((prd_new[0] == 2'h0) |-> !fire[0]) // R12
    else $error("interrupt with zero period");

  // Writing a period equal to the count fires at once
  irq_prd_eq_a: assert property (prd_wr[0] && (prd_new[0] == st_r.irq_cnt)
      && (prd_new[0] != 2'h0) && st_r.irq_en && !st_r.irq_flag |=> pwm_irq_out_o) // R09
    else $error("equal period write did not fire");

  // Clear with no new pulse drops the flag
  irq_flag_clr_a: assert property (clr_irq && !fire[0] |=> !st_r.irq_flag) // R18
    else $error("interrupt flag not cleared");

  // Count moves by at most one per clock
  irq_step_a: assert property (##1 (st_r.irq_cnt == 2'h0)
      || (st_r.irq_cnt == $past(st_r.irq_cnt))
      || (st_r.irq_cnt == $past(st_r.irq_cnt) + 2'h1)) // R19
    else $error("interrupt count jumped");

  // Main scenarios
  irq_pulse_c:   cover property (pwm_irq_out_o);
  irq_pend_c:    cover property (st_r.irq_flag && clr_irq ##1 pwm_irq_out_o);
  conva_flag_c:  cover property (st_r.conva_flag && fire[1]);
  prd_evt_c:     cover property (prd_wr[0] && irq_evt_i);

endmodule // etp_event_trigger

// ### etp_far_model.sv
// Purpose : Far-side sink that counts interrupt and conversion start pulses.
// Assumes : Pulses are one clock wide and synchronous to sys_clk_i.
// Notes   : Counts wrap at 256; the bench stays far below that.
`timescale 1ns/1ps
module etp_far_model (
  input  wire logic       sys_clk_i,
  input  wire logic       irq_i,    // Interrupt line into the CPU side
  input  wire logic       adc_i,    // Conversion A start into the ADC
  output logic      [7:0] irq_n_o,  // Interrupts taken
  output logic      [7:0] adc_n_o   // Conversions started
);
  logic [7:0] irq_n = 8'h00; // Interrupts counted so far
  logic [7:0] adc_n = 8'h00; // Conversion starts counted so far
  assign irq_n_o = irq_n;
  assign adc_n_o = adc_n;
  // Each high cycle is one pulse taken
  always @(posedge sys_clk_i) begin
    if (irq_i === 1'h1) irq_n <= irq_n + 8'h01;
    if (adc_i === 1'h1) adc_n <= adc_n + 8'h01;
  end
endmodule // etp_far_model

// ### event_trigger_prescaler_tb_top.sv
// Purpose : Self-checking bench for the event trigger prescaler.
// Assumes : bready and rready stay high, so every answer is taken at once.
// Notes   : Read answers are noted in a queue and compared by a monitor.
`timescale 1ns/1ps
module event_trigger_prescaler_tb_top;
  logic        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
  logic        ie = 1'h0, ce = 1'h0, one = 1'h1;
  logic [7:0]  awa = 8'h00, ara = 8'h00, ni, na;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  bresp, rresp, lb;
  logic        awr, wr_rdy, bv, arr, rv, irq, adc;
  logic [33:0] rq[$];  // Expected read answers, oldest first
  int          err_total = 0, checks_done = 0, t = 0, n, p, e = 0, q = 0;
  always #25 clk = ~clk;
  etp_event_trigger uut (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(one), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(one),
    .irq_evt_i(ie), .conv_a_evt_i(ce), .pwm_irq_out_o(irq), .adc_start_a_pulse_o(adc));
  etp_far_model far (.sys_clk_i(clk), .irq_i(irq), .adc_i(adc), .irq_n_o(ni), .adc_n_o(na));
  task automatic chk(input logic [33:0] s, input logic [33:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, x);
    end
  endtask
  // Monitor: each read answer is held against the oldest note
  always @(negedge clk) if (rv === 1'h1) chk({rresp, rdat}, rq.pop_front());
  task automatic cyc(input int k); repeat (k) @(posedge clk); endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw, ta, tw;
    ga = 1'h0; gw = 1'h0; awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1;
    while (!(ga && gw)) begin
      @(negedge clk); ta = !ga && awr === 1'h1; tw = !gw && wr_rdy === 1'h1;
      @(posedge clk); if (ta) awv <= 1'h0; if (tw) wv <= 1'h0; ga |= ta; gw |= tw;
    end
    do begin @(negedge clk); ta = bv === 1'h1; lb = bresp; @(posedge clk); end while (!ta);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    logic ta;
    rq.push_back(x); ara <= a; arv <= 1'h1;
    do begin @(negedge clk); ta = arr === 1'h1; @(posedge clk); end while (!ta);
    arv <= 1'h0;
    do begin @(negedge clk); ta = rv === 1'h1; @(posedge clk); end while (!ta);
  endtask
  // Event strobes held for k back-to-back cycles
  task automatic ev(input logic i, input logic c, input int k);
    ie <= i; ce <= c; repeat (k) @(posedge clk); ie <= 1'h0; ce <= 1'h0; @(posedge clk);
  endtask
  task automatic done; t++; $display("test %0d done", t); endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up;
  end
  initial begin
    n = $urandom(1);
    repeat (3) @(posedge clk); rst_n <= 1'h1;
    rd(8'h00, 34'h0); rd(8'h08, 34'h0); rd(8'h14, 34'h200000000);
    wr(8'h14, 32'hF); chk(lb, 2'h2); done;
    wr(8'h04, 32'h8);
    for (p = 1; p < 4; p++) begin
      wr(8'h00, p); if (p > 1) ev(1, 0, p - 1);
      rd(8'h00, 34'((p - 1) * 4 + p)); ev(1, 0, 1); cyc(2);
      rd(8'h00, 34'(p)); rd(8'h08, 34'h1);
      wr(8'h0C, 32'h1); rd(8'h08, 34'h0);
    end
    chk(ni, 8'h3); done;
    wr(8'h00, 32'h1); ev(1, 0, 1); cyc(2); ev(1, 0, 3); rd(8'h00, 34'h5);
    chk(ni, 8'h4); wr(8'h0C, 32'h1); cyc(3); chk(ni, 8'h5);
    rd(8'h00, 34'h1); wr(8'h0C, 32'h1); done;
    wr(8'h04, 32'h0); wr(8'h00, 32'h2); ev(1, 0, 3); rd(8'h00, 34'hA); chk(ni, 8'h5);
    wr(8'h04, 32'h8); cyc(3); chk(ni, 8'h6); wr(8'h0C, 32'h1);
    wr(8'h00, 32'h3); ev(1, 0, 2); rd(8'h00, 34'hB); wr(8'h00, 32'h2); cyc(3);
    chk(ni, 8'h7); rd(8'h00, 34'h2); wr(8'h0C, 32'h1); done;
    wr(8'h00, 32'h0); ev(1, 0, 2); rd(8'h00, 34'h0);
    wr(8'h10, 32'h1); cyc(3); chk(ni, 8'h7); done;
    wr(8'h00, 32'h2); ev(1, 0, 1);
    fork wr(8'h00, 32'h3); begin @(posedge clk); ev(1, 0, 1); end join
    rd(8'h00, 34'hB); done;
    wr(8'h10, 32'h1); cyc(3); chk(ni, 8'h8); rd(8'h00, 34'h3); wr(8'h0C, 32'h1); done;
    wr(8'h04, 32'h808);
    for (p = 0; p < 4; p++) begin
      n = $urandom_range(8, 1); wr(8'h00, (p << 8) | 3); ev(0, 1, n); cyc(2);
      if (p > 0) begin e += (q + n) / p; q = (q + n) % p; end
      chk(na, 8'(e));
      rd(8'h00, 34'((q << 10) | (p << 8) | 3));
    end
    rd(8'h08, 34'h4); wr(8'h04, 32'h8); ev(0, 1, 3); cyc(2); chk(na, 8'(e)); done;
    wrap_up;
  end
endmodule // event_trigger_prescaler_tb_top
